// ==== verilog/csc_pkg.sv ====
// Shared constants, register map, reset values and helpers for the pixel
// formatter, sync selector and half-band chroma filter.
// Assumes one 20 MHz pixel clock and registers reached over AXI4-Lite.
package csc_pkg;
	// Timing.
	localparam int CLK_PERIOD_NS = 50;
	localparam int ACT_H_WINDOW_NS = 100000;
	localparam int ACT_H_CYC = ACT_H_WINDOW_NS / CLK_PERIOD_NS;
	localparam int ACT_V_WINDOW_NS = 100000000;
	localparam int ACT_V_CYC = ACT_V_WINDOW_NS / CLK_PERIOD_NS;
	localparam int ACT_CNT_W = 21;
	localparam int SEP_VS_NS = 10000;
	localparam int SEP_VS_CYC = (SEP_VS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Register indices; byte address is four times the index.
	localparam logic [5:0] IDX_SYNC_SEL = 6'h0e;
	localparam logic [5:0] IDX_SLICER = 6'h10;
	localparam logic [5:0] IDX_STATUS = 6'h14;
	localparam logic [5:0] IDX_OUT_FMT = 6'h15;
	localparam logic [5:0] IDX_CSC_CTRL = 6'h18;
	localparam logic [5:0] IDX_SOG_LPF = 6'h1a;
	localparam logic [5:0] IDX_COEF0 = 6'h20;
	localparam logic [5:0] IDX_COEF_LAST = 6'h28;
	// Field positions.
	localparam int SS_AUTO_H = 0;
	localparam int SS_AUTO_V = 1;
	localparam int SS_H_SRC = 2;
	localparam int SS_V_SRC = 3;
	localparam int SS_HPOL = 4;
	localparam int SS_SOG_LSB = 5;
	localparam int ST_HS = 0;
	localparam int ST_VS = 1;
	localparam int ST_SOG = 2;
	localparam int ST_HS_B = 3;
	localparam int FMT_422_BIT = 1;
	localparam int CSC_BYPASS_BIT = 4;
	// Reset values.
	localparam logic [6:0] SYNC_SEL_RST = 7'h00;
	localparam logic [4:0] SLICER_RST = 5'h0b;
	localparam logic [1:0] LPF_RST = 2'h0;
	localparam logic FMT422_RST = 1'b0;
	localparam logic BYPASS_RST = 1'b1;
	// Coefficient order: Y(G,B,R), Cb(G,B,R), Cr(G,B,R); index 0 is Y from G.
	localparam logic [8:0][15:0] COEF_RST = {16'h1000, 16'hfe88, 16'hf178, 16'hfc55,
		16'h1000, 16'hf3ab, 16'h06ce, 16'h024f, 16'h16e3};
	localparam logic [15:0] COEF_UNITY = 16'h1000;
	localparam int COEF_FRAC = 12;
	localparam logic [9:0] CHROMA_OFS = 10'h200;
	// Half-band filter: centre tap and odd taps h1..h13, scaled by 2^HB_SHIFT.
	localparam int HB_TAPS = 27;
	localparam int HB_MID = 13;
	localparam int HB_SHIFT = 10;
	localparam logic [11:0] HB_MID_COEF = 12'h200;
	localparam logic [6:0][11:0] HB_ODD = {12'h004, 12'hffa, 12'h00e, 12'hfe6,
		12'h030, 12'hfa0, 12'h13e};
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {HS_FROM_PIN = 1'b0, HS_FROM_SOG = 1'b1} hs_src_t;
	typedef enum logic {VS_FROM_PIN = 1'b0, VS_FROM_SEP = 1'b1} vs_src_t;

	function automatic logic [9:0] clamp10(input logic signed [31:0] v);
		if (v < 32'sh0)
			return 10'h000;
		if (v > 32'sh3ff)
			return 10'h3ff;
		return v[9:0];
	endfunction : clamp10
endpackage : csc_pkg

// ==== verilog/halfband_chroma.sv ====
// Half-band chroma low-pass for the 4:2:2 path, with luma delayed to match.
// Assumes one new pixel on every clock edge from the colour converter.
`timescale 1ns/10ps
module halfband_chroma (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Converted pixel in.
	input wire logic [9:0] y_in,
	input wire logic [9:0] cb_in,
	input wire logic [9:0] cr_in,
	// Filtered pixel out, fifteen cycles later.
	output logic [9:0] y_out,
	output logic [9:0] cb_out,
	output logic [9:0] cr_out
);
	typedef struct packed {
		logic [csc_pkg::HB_TAPS-1:0][9:0] cb_t;
		logic [csc_pkg::HB_TAPS-1:0][9:0] cr_t;
		logic [csc_pkg::HB_MID:0][9:0] y_t;
		logic [9:0] y_o;
		logic [9:0] cb_o;
		logic [9:0] cr_o;
	} fir_state_t;

	fir_state_t q;
	fir_state_t d;

	// Only the centre and odd taps are non-zero, so symmetric pairs share a multiply.
	function automatic logic [9:0] halfband(input logic [csc_pkg::HB_TAPS-1:0][9:0] t);
		logic signed [31:0] acc;
		acc = $signed({20'h0, csc_pkg::HB_MID_COEF}) * $signed({22'h0, t[csc_pkg::HB_MID]});
		for (int k = 0; k < 7; k++)
		begin
			acc = acc + $signed({{20{csc_pkg::HB_ODD[k][11]}}, csc_pkg::HB_ODD[k]})
				* ($signed({22'h0, t[csc_pkg::HB_MID - 2 * k - 1]})
				+ $signed({22'h0, t[csc_pkg::HB_MID + 2 * k + 1]}));
		end
		return csc_pkg::clamp10(acc >>> csc_pkg::HB_SHIFT);
	endfunction : halfband

	always_comb
	begin
		d = q;
		d.cb_t = {q.cb_t[csc_pkg::HB_TAPS-2:0], cb_in};
		d.cr_t = {q.cr_t[csc_pkg::HB_TAPS-2:0], cr_in};
		d.y_t = {q.y_t[csc_pkg::HB_MID-1:0], y_in};
		d.y_o = q.y_t[csc_pkg::HB_MID];
		d.cb_o = halfband(q.cb_t);
		d.cr_o = halfband(q.cr_t);
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign y_out = q.y_o;
	assign cb_out = q.cb_o;
	assign cr_out = q.cr_o;
endmodule : halfband_chroma

// ==== verilog/csc_chroma_sync_select_formatter.sv ====
// Colour conversion, chroma downsampling, output formatting and sync
// selection for a triple-channel digitizer back end.
// Assumes pixels arrive on every edge of the 20 MHz clock; sync pins are
// asynchronous; registers are reached over AXI4-Lite.
//
// Overview of operation
// - Conversion bypass bit, bypassed after reset.
// - Programmable coefficients, HD matrix at reset.
// - Half-band 27-tap chroma downsampling to 4:2:2.
// - One bit picks 30-bit or 20-bit format.
// - 4:2:2: luma on green, Cb/Cr alternate blue.
// - Downsampling follows colour conversion.
// - 4:4:4: Y green, Cb blue, Cr red.
// - Red bus floats in 4:2:2 mode.
// - No single-bus 10-bit 4:2:2 output.
// - Sync source chosen from input activity.
// - Slicer result drives sliced sync output.
// - Threshold setting 0..31, resets to 11.
// - Comparator low-pass, three cutoffs, bypassed at reset.
// - Hsync and vsync activity readable in status.
// - Auto mode, both active: use sync pins.
// - Auto, hsync only: vsync from composite.
// - Auto, no pin activity: use sync-on-green.
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module csc_chroma_sync_select_formatter #(
	parameter int ACT_V_CYC = csc_pkg::ACT_V_CYC
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset_n,
	// AXI4-Lite write channels.
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels.
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Digitized 4:4:4 pixels.
	input wire logic [9:0] pix_g,
	input wire logic [9:0] pix_b,
	input wire logic [9:0] pix_r,
	// Sync pins and sliced sync-on-green comparators.
	input wire logic hsync_a_in,
	input wire logic hsync_b_in,
	input wire logic vsync_in,
	input wire logic [2:0] sync_on_green_input,
	// Output buses.
	output logic [9:0] green_output_bus,
	output logic [9:0] blue_output_bus,
	output logic [9:0] red_output_bus,
	output logic red_oe_n,
	// Active syncs and analog slicer controls.
	output logic hsync_out,
	output logic vsync_out,
	output logic sliced_sync_output,
	output logic [4:0] slicer_threshold_setting,
	output logic [1:0] sog_lpf_select,
	output logic [1:0] sog_input_select
);
	typedef struct packed {
		logic aw_rdy;
		logic w_rdy;
		logic [5:0] awidx;
		logic [31:0] wdat;
		logic [3:0] wstb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [6:0] sync_sel;
		logic [4:0] slicer;
		logic [1:0] lpf;
		logic fmt422;
		logic bypass;
		logic [8:0][15:0] coef;
		logic [5:0] s1;
		logic [5:0] s2;
		logic [3:0] prev;
		logic [3:0][csc_pkg::ACT_CNT_W-1:0] act_cnt;
		logic [10:0] win_cnt;
		logic [10:0] hi_cnt;
		logic hs_inv;
		logic hs_b_sel;
		logic [7:0] sep_cnt;
		logic vs_sep;
		csc_pkg::hs_src_t hs_src;
		csc_pkg::vs_src_t vs_src;
		logic hs_out;
		logic vs_out;
		logic sliced;
		logic [9:0] csc_y;
		logic [9:0] csc_cb;
		logic [9:0] csc_cr;
		logic phase;
		logic [9:0] green;
		logic [9:0] blue;
		logic [9:0] red;
		logic red_oe_n;
	} state_t;

	state_t q;
	state_t d;
	logic [1:0] rst_sync_q;
	logic rst_n_s;
	logic [9:0] fy;
	logic [9:0] fcb;
	logic [9:0] fcr;
	logic sog_now;
	logic [3:0] cur;
	logic [3:0] act;
	logic hs_act;
	logic hs_pin_raw;
	logic hs_pin;
	logic comp;
	logic hs_rise;
	logic aw_fire;
	logic w_fire;
	logic ar_fire;
	logic wr_en;
	logic [5:0] ar_idx;
	logic [3:0] coef_k;
	logic [31:0] rd_val;

	function automatic logic is_mapped(input logic [5:0] idx);
		return idx == csc_pkg::IDX_SYNC_SEL || idx == csc_pkg::IDX_SLICER
			|| idx == csc_pkg::IDX_STATUS || idx == csc_pkg::IDX_OUT_FMT
			|| idx == csc_pkg::IDX_CSC_CTRL || idx == csc_pkg::IDX_SOG_LPF
			|| (idx >= csc_pkg::IDX_COEF0 && idx <= csc_pkg::IDX_COEF_LAST);
	endfunction : is_mapped

	// Sum of three signed products, back to 10 bits with an offset for chroma.
	function automatic logic [9:0] csc_row(input logic [9:0] g, input logic [9:0] b,
		input logic [9:0] r, input logic [15:0] kg, input logic [15:0] kb,
		input logic [15:0] kr, input logic [9:0] ofs);
		logic signed [31:0] acc;
		acc = $signed({22'h0, g}) * $signed({{16{kg[15]}}, kg})
			+ $signed({22'h0, b}) * $signed({{16{kb[15]}}, kb})
			+ $signed({22'h0, r}) * $signed({{16{kr[15]}}, kr});
		return csc_pkg::clamp10((acc >>> csc_pkg::COEF_FRAC) + $signed({22'h0, ofs}));
	endfunction : csc_row

	// The reset is released through two flops so every state flop leaves reset together.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n_s = rst_sync_q[1];

	halfband_chroma u_halfband (
		.clock(clock),
		.rst_n(rst_n_s),
		.y_in(q.csc_y),
		.cb_in(q.csc_cb),
		.cr_in(q.csc_cr),
		.y_out(fy),
		.cb_out(fcb),
		.cr_out(fcr)
	);

	always_comb
	begin
		d = q;
		aw_fire = awvalid && q.aw_rdy;
		w_fire = wvalid && q.w_rdy;
		ar_fire = arvalid && q.ar_rdy;
		wr_en = !q.aw_rdy && !q.w_rdy && !q.bvalid;
		ar_idx = araddr[7:2];
		coef_k = 4'h0;
		rd_val = 32'h0;
		// Pins pass two flops; only the second stage is looked at.
		d.s1 = {sync_on_green_input, vsync_in, hsync_b_in, hsync_a_in};
		d.s2 = q.s1;
		unique case (q.sync_sel[csc_pkg::SS_SOG_LSB +: 2])
			2'h0: sog_now = q.s2[3];
			2'h1: sog_now = q.s2[4];
			default: sog_now = q.s2[5];
		endcase
		cur = {sog_now, q.s2[2:0]};
		d.prev = cur;
		// Each edge reloads a window; a channel is active while its window runs.
		for (int i = 0; i < 4; i++)
		begin
			act[i] = q.act_cnt[i] != '0;
			if (cur[i] != q.prev[i])
				d.act_cnt[i] = (i == 2) ? csc_pkg::ACT_CNT_W'(ACT_V_CYC)
					: csc_pkg::ACT_CNT_W'(csc_pkg::ACT_H_CYC);
			else if (act[i])
				d.act_cnt[i] = q.act_cnt[i] - 21'h1;
		end
		hs_act = act[0] || act[1];
		hs_pin_raw = act[0] ? q.s2[0] : q.s2[1];
		d.hs_b_sel = !act[0];
		// Polarity: the level held for most of a window is the inactive one.
		if (q.win_cnt == 11'(csc_pkg::ACT_H_CYC - 1))
		begin
			d.win_cnt = 11'h0;
			d.hi_cnt = 11'h0;
			d.hs_inv = q.hi_cnt > 11'(csc_pkg::ACT_H_CYC / 2);
		end
		else
		begin
			d.win_cnt = q.win_cnt + 11'h1;
			d.hi_cnt = q.hi_cnt + {10'h0, hs_pin_raw};
		end
		hs_pin = hs_pin_raw ^ (q.hs_inv && !q.sync_sel[csc_pkg::SS_HPOL]);
		// Source selection; a set override bit hands the choice to software.
		if (!q.sync_sel[csc_pkg::SS_AUTO_H])
			d.hs_src = hs_act ? csc_pkg::HS_FROM_PIN : csc_pkg::HS_FROM_SOG;
		else
			d.hs_src = csc_pkg::hs_src_t'(q.sync_sel[csc_pkg::SS_H_SRC]);
		if (!q.sync_sel[csc_pkg::SS_AUTO_V])
			d.vs_src = (act[2] && hs_act) ? csc_pkg::VS_FROM_PIN
				: csc_pkg::VS_FROM_SEP;
		else
			d.vs_src = csc_pkg::vs_src_t'(q.sync_sel[csc_pkg::SS_V_SRC]);
		comp = (q.hs_src == csc_pkg::HS_FROM_PIN) ? hs_pin : sog_now;
		// Separator: a long active pulse marks the vertical interval, a short one ends it.
		// Below a 10 Hz field rate the vsync pin gaps outlast its 100 ms window, so auto mode falls back to the separator.
		if (comp)
		begin
			if (q.sep_cnt != 8'(csc_pkg::SEP_VS_CYC))
				d.sep_cnt = q.sep_cnt + 8'h1;
			if (q.sep_cnt >= 8'(csc_pkg::SEP_VS_CYC - 1))
				d.vs_sep = 1'b1;
		end
		else
		begin
			d.sep_cnt = 8'h0;
			if (q.sep_cnt != 8'h0 && q.sep_cnt < 8'(csc_pkg::SEP_VS_CYC))
				d.vs_sep = 1'b0;
		end
		d.hs_out = comp;
		d.vs_out = (q.vs_src == csc_pkg::VS_FROM_PIN) ? q.s2[2] : q.vs_sep;
		d.sliced = sog_now;
		hs_rise = comp && !q.hs_out;
		d.phase = hs_rise ? 1'b0 : !q.phase;
		// Colour conversion comes first; the filter works on its output.
		if (q.bypass)
		begin
			d.csc_y = pix_g;
			d.csc_cb = pix_b;
			d.csc_cr = pix_r;
		end
		else
		begin
			d.csc_y = csc_row(pix_g, pix_b, pix_r, q.coef[0], q.coef[1], q.coef[2],
				10'h000);
			d.csc_cb = csc_row(pix_g, pix_b, pix_r, q.coef[3], q.coef[4], q.coef[5],
				csc_pkg::CHROMA_OFS);
			d.csc_cr = csc_row(pix_g, pix_b, pix_r, q.coef[6], q.coef[7], q.coef[8],
				csc_pkg::CHROMA_OFS);
		end
		// Only two formats exist; there is no single-bus multiplexed mode.
		if (q.fmt422)
		begin
			d.green = fy;
			d.blue = q.phase ? fcr : fcb;
			d.red = 10'h000;
			d.red_oe_n = 1'b1;
		end
		else
		begin
			d.green = q.csc_y;
			d.blue = q.csc_cb;
			d.red = q.csc_cr;
			d.red_oe_n = 1'b0;
		end
		// Write side: address and data are taken in either order.
		if (aw_fire)
		begin
			d.aw_rdy = 1'b0;
			d.awidx = awaddr[7:2];
		end
		if (w_fire)
		begin
			d.w_rdy = 1'b0;
			d.wdat = wdata;
			d.wstb = wstrb;
		end
		if (wr_en)
		begin
			d.bvalid = 1'b1;
			d.bresp = is_mapped(q.awidx) ? csc_pkg::RESP_OKAY : csc_pkg::RESP_SLVERR;
			coef_k = 4'(q.awidx - csc_pkg::IDX_COEF0);
			if (q.wstb[0])
			begin
				unique case (q.awidx)
					csc_pkg::IDX_SYNC_SEL: d.sync_sel = q.wdat[6:0];
					csc_pkg::IDX_SLICER: d.slicer = q.wdat[4:0];
					csc_pkg::IDX_OUT_FMT: d.fmt422 = q.wdat[csc_pkg::FMT_422_BIT];
					csc_pkg::IDX_CSC_CTRL: d.bypass = q.wdat[csc_pkg::CSC_BYPASS_BIT];
					csc_pkg::IDX_SOG_LPF: d.lpf = q.wdat[1:0];
					default:
					begin
						if (is_mapped(q.awidx) && q.awidx >= csc_pkg::IDX_COEF0)
							d.coef[coef_k][7:0] = q.wdat[7:0];
					end
				endcase
			end
			if (q.wstb[1] && q.awidx >= csc_pkg::IDX_COEF0 && is_mapped(q.awidx))
				d.coef[coef_k][15:8] = q.wdat[15:8];
		end
		if (q.bvalid && bready)
		begin
			d.bvalid = 1'b0;
			d.aw_rdy = 1'b1;
			d.w_rdy = 1'b1;
		end
		// Read side.
		unique case (ar_idx)
			csc_pkg::IDX_SYNC_SEL: rd_val = {25'h0, q.sync_sel};
			csc_pkg::IDX_SLICER: rd_val = {27'h0, q.slicer};
			csc_pkg::IDX_STATUS: rd_val = {28'h0, q.hs_b_sel, act[3], act[2], hs_act};
			csc_pkg::IDX_OUT_FMT: rd_val = {30'h0, q.fmt422, 1'b0};
			csc_pkg::IDX_CSC_CTRL: rd_val = {27'h0, q.bypass, 4'h0};
			csc_pkg::IDX_SOG_LPF: rd_val = {30'h0, q.lpf};
			default:
			begin
				if (is_mapped(ar_idx))
					rd_val = {16'h0, q.coef[4'(ar_idx - csc_pkg::IDX_COEF0)]};
			end
		endcase
		if (ar_fire)
		begin
			d.ar_rdy = 1'b0;
			d.rvalid = 1'b1;
			d.rdata = rd_val;
			d.rresp = is_mapped(ar_idx) ? csc_pkg::RESP_OKAY : csc_pkg::RESP_SLVERR;
		end
		if (q.rvalid && rready)
		begin
			d.rvalid = 1'b0;
			d.ar_rdy = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			q <= '0;
			q.aw_rdy <= 1'b1;
			q.w_rdy <= 1'b1;
			q.ar_rdy <= 1'b1;
			q.sync_sel <= csc_pkg::SYNC_SEL_RST;
			q.slicer <= csc_pkg::SLICER_RST;
			q.lpf <= csc_pkg::LPF_RST;
			q.fmt422 <= csc_pkg::FMT422_RST;
			q.bypass <= csc_pkg::BYPASS_RST;
			q.coef <= csc_pkg::COEF_RST;
		end
		else
			q <= d;
	end

	assign awready = q.aw_rdy;
	assign wready = q.w_rdy;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign arready = q.ar_rdy;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign green_output_bus = q.green;
	assign blue_output_bus = q.blue;
	assign red_output_bus = q.red;
	assign red_oe_n = q.red_oe_n;
	assign hsync_out = q.hs_out;
	assign vsync_out = q.vs_out;
	assign sliced_sync_output = q.sliced;
	assign slicer_threshold_setting = q.slicer;
	assign sog_lpf_select = q.lpf;
	assign sog_input_select = q.sync_sel[csc_pkg::SS_SOG_LSB +: 2];

	default clocking cb_main @(posedge clock);
	endclocking
	default disable iff (!rst_n_s);

	sequence s_auto_both;
		!q.sync_sel[csc_pkg::SS_AUTO_H] && !q.sync_sel[csc_pkg::SS_AUTO_V];
	endsequence
	sequence s_rd_status;
		ar_fire && ar_idx == csc_pkg::IDX_STATUS;
	endsequence

	property p_bypass_reset;
		$rose(rst_n_s) |-> q.bypass && q.slicer == csc_pkg::SLICER_RST && q.lpf == 2'h0;
	endproperty
	a_bypass_reset: assert property (p_bypass_reset) else $error("bypass reset");
	property p_bypass_path;
		q.bypass |=> q.csc_y == $past(pix_g) && q.csc_cr == $past(pix_r);
	endproperty
	a_bypass_path: assert property (p_bypass_path) else $error("bypass path");
	property p_coef_reset;
		$rose(rst_n_s) |-> q.coef == csc_pkg::COEF_RST;
	endproperty
	a_coef_reset: assert property (p_coef_reset) else $error("coef reset");
	property p_unity;
		!q.bypass && q.coef[0] == csc_pkg::COEF_UNITY && q.coef[1] == 16'h0000
			&& q.coef[2] == 16'h0000 |=> q.csc_y == $past(pix_g);
	endproperty
	a_unity: assert property (p_unity) else $error("unity gain");
	property p_444_map;
		!q.fmt422 |=> !q.red_oe_n && q.red == $past(q.csc_cr) && q.blue == $past(q.csc_cb);
	endproperty
	a_444_map: assert property (p_444_map) else $error("4:4:4 mapping");
	property p_422_hiz;
		q.fmt422 |=> q.red_oe_n && q.green == $past(fy);
	endproperty
	a_422_hiz: assert property (p_422_hiz) else $error("red not floated");
	property p_chroma_alt;
		q.fmt422 && !hs_rise |=> q.phase != $past(q.phase);
	endproperty
	a_chroma_alt: assert property (p_chroma_alt) else $error("chroma phase");
	property p_auto_sog;
		s_auto_both ##0 (!hs_act && !act[2]) |=> q.hs_src == csc_pkg::HS_FROM_SOG
			&& q.vs_src == csc_pkg::VS_FROM_SEP;
	endproperty
	a_auto_sog: assert property (p_auto_sog) else $error("sog not chosen");
	property p_auto_pins;
		s_auto_both ##0 (hs_act && act[2]) |=> q.hs_src == csc_pkg::HS_FROM_PIN
			&& q.vs_src == csc_pkg::VS_FROM_PIN;
	endproperty
	a_auto_pins: assert property (p_auto_pins) else $error("pins not chosen");
	property p_auto_csync;
		s_auto_both ##0 (hs_act && !act[2]) |=> q.vs_src == csc_pkg::VS_FROM_SEP
			##1 vsync_out == $past(q.vs_sep);
	endproperty
	a_auto_csync: assert property (p_auto_csync) else $error("csync vsync");
	property p_status;
		s_rd_status |=> rvalid && rdata[csc_pkg::ST_HS] == $past(hs_act)
			&& rdata[csc_pkg::ST_VS] == $past(act[2]);
	endproperty
	a_status: assert property (p_status) else $error("status read");
	property p_sliced;
		1'b1 |=> sliced_sync_output == $past(sog_now);
	endproperty
	a_sliced: assert property (p_sliced) else $error("sliced sync");
endmodule : csc_chroma_sync_select_formatter

// ==== sim/video_sink.sv ====
// Downstream processor model that latches the three output buses each clock.
// Assumes it shares the pixel clock with the formatter.
`timescale 1ns/10ps
module video_sink (
	// Clock.
	input wire logic clock,
	// Buses from the formatter.
	input wire logic [9:0] green_bus,
	input wire logic [9:0] blue_bus,
	input wire logic [9:0] red_bus,
	input wire logic red_oe_n,
	// Latched samples.
	output logic [9:0] g_q,
	output logic [9:0] b_q,
	output logic [9:0] r_q
);
	logic [9:0] red_wire;
	// A floating red bus shows the inverse of its last value, never a stale copy.
	assign red_wire = red_oe_n ? ~r_q : red_bus;
	always_ff @(posedge clock)
	begin
		g_q <= green_bus;
		b_q <= blue_bus;
		r_q <= red_wire;
	end
endmodule : video_sink

// ==== sim/tb.sv ====
// Self-checking bench for the formatter and sync selector.
// Assumes the sink model and the design files are compiled first.
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; \
$display("mismatch %s exp %h got %h", n, e, s); end end
module tb;
	logic clock = 0, reset_n = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, red_oe_n;
	logic [1:0] bresp, rresp, lpf, sog_sel;
	logic [31:0] rdata;
	logic [9:0] pix_g = 0, pix_b = 0, pix_r = 0, gb, bb, rb, g_q, b_q, r_q;
	logic hsync_a_in = 0, vsync_in = 0, hsync_out, vsync_out, sliced;
	logic [2:0] sync_on_green_input = 0;
	logic [4:0] thr;
	int err_total = 0, samples_checked = 0;
	csc_chroma_sync_select_formatter #(.ACT_V_CYC(64)) u_dut (.clock(clock),
		.reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .pix_g(pix_g), .pix_b(pix_b), .pix_r(pix_r),
		.hsync_a_in(hsync_a_in), .hsync_b_in(1'b0), .vsync_in(vsync_in),
		.sync_on_green_input(sync_on_green_input), .green_output_bus(gb),
		.blue_output_bus(bb), .red_output_bus(rb), .red_oe_n(red_oe_n),
		.hsync_out(hsync_out), .vsync_out(vsync_out), .sliced_sync_output(sliced),
		.slicer_threshold_setting(thr), .sog_lpf_select(lpf), .sog_input_select(sog_sel));
	video_sink u_sink (.clock(clock), .green_bus(gb), .blue_bus(bb), .red_bus(rb),
		.red_oe_n(red_oe_n), .g_q(g_q), .b_q(b_q), .r_q(r_q));
	initial
	begin
		forever #25 clock = ~clock;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	task automatic wr(input logic [5:0] i, input logic [31:0] d);
		@(posedge clock);
		awaddr <= {i, 2'b00};
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do @(posedge clock); while (!(awready === 1'b1 && wready === 1'b1));
		awvalid <= 0;
		wvalid <= 0;
		do @(posedge clock); while (bvalid !== 1'b1);
		bready <= 0;
		`CHK("bresp", 2'h0, bresp)
	endtask : wr
	task automatic rd(input logic [5:0] i, input logic [31:0] e, input logic [1:0] er);
		@(posedge clock);
		araddr <= {i, 2'b00};
		arvalid <= 1;
		rready <= 1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge clock); while (rvalid !== 1'b1);
		rready <= 0;
		`CHK("rdata", e, rdata)
		`CHK("rresp", er, rresp)
	endtask : rd
	task automatic test_reset();
		`CHK("thr port", 5'h0b, thr)
		`CHK("lpf port", 2'h0, lpf)
		rd(6'h18, 32'h10, 2'h0);
		rd(6'h15, 32'h0, 2'h0);
		rd(6'h10, 32'h0b, 2'h0);
		rd(6'h20, 32'h16e3, 2'h0);
		rd(6'h21, 32'h024f, 2'h0);
		rd(6'h22, 32'h06ce, 2'h0);
		rd(6'h3f, 32'h0, 2'h2);
		$display("test reset done");
	endtask : test_reset
	task automatic test_pixels();
		logic [9:0] b0;
		pix_g <= 10'h123;
		pix_b <= 10'h080;
		pix_r <= 10'h040;
		repeat (20) @(posedge clock);
		`CHK("bypass g", 10'h123, g_q)
		`CHK("bypass b", 10'h080, b_q)
		`CHK("bypass r", 10'h040, r_q)
		for (int k = 0; k < 9; k++)
			wr(6'h20 + k[5:0], (k % 4 == 0) ? 32'h1000 : 32'h0);
		wr(6'h18, 32'h0);
		repeat (20) @(posedge clock);
		`CHK("csc y", 10'h123, g_q)
		`CHK("csc cb", 10'h280, b_q)
		`CHK("csc cr", 10'h240, r_q)
		`CHK("oe 444", 1'b0, red_oe_n)
		wr(6'h15, 32'h2);
		repeat (40) @(posedge clock);
		#1;
		b0 = b_q;
		@(posedge clock);
		#1;
		`CHK("422 alt", 1'b1, (b0 === 10'h280 && b_q === 10'h240) || (b0 === 10'h240 && b_q === 10'h280))
		`CHK("422 y", 10'h123, g_q)
		`CHK("oe 422", 1'b1, red_oe_n)
		$display("test pixels done");
	endtask : test_pixels
	task automatic pulse(input int n, input logic h, input logic v);
		for (int k = 0; k < n; k++)
		begin
			@(posedge clock);
			sync_on_green_input[0] <= k[0];
			if (h)
				hsync_a_in <= k[0];
			// Vsync trails hsync by one clock so their leading edges never coincide.
			@(posedge clock);
			if (v)
				vsync_in <= k[0];
			repeat (9) @(posedge clock);
			`CHK("sliced", k[0], sliced)
			if (!h)
				`CHK("hsync_out", k[0], hsync_out)
			if (v)
				`CHK("vsync_out", k[0], vsync_out)
		end
	endtask : pulse
	task automatic test_sync();
		wr(6'h10, 32'h1f);
		`CHK("thr max", 5'h1f, thr)
		for (int k = 1; k < 4; k++)
		begin
			wr(6'h1a, k);
			`CHK("lpf", k[1:0], lpf)
		end
		pulse(6, 0, 0);
		rd(6'h14, 32'hc, 2'h0);
		pulse(6, 1, 1);
		rd(6'h14, 32'h7, 2'h0);
		pulse(10, 1, 0);
		rd(6'h14, 32'h5, 2'h0);
		// Polarity override stays zero in every sync select write below.
		wr(6'h0e, 32'h0a);
		rd(6'h0e, 32'h0a, 2'h0);
		wr(6'h0e, 32'h0f);
		pulse(4, 0, 0);
		$display("test sync done");
	endtask : test_sync
	initial
	begin
		repeat (20000) @(posedge clock);
		err_total++;
		summarize();
	end
	initial
	begin
		repeat (6) @(posedge clock);
		reset_n <= 1;
		repeat (3) @(posedge clock);
		test_reset();
		test_pixels();
		test_sync();
		summarize();
	end
endmodule : tb
